// File: src/bcrd_pkg.sv
// shared constants and types for the buck control register block
package bcrd_pkg;
  // serial slave address
  localparam logic [6:0] SLAVE_ADDR     = 7'h64;
  // register offsets
  localparam logic [7:0] OFS_SETPOINT   = 8'h00;
  localparam logic [7:0] OFS_CONTROL_0  = 8'h01;
  localparam logic [7:0] OFS_CONTROL_1  = 8'h05;
  // field positions
  localparam int         SETPOINT_W     = 6;
  localparam int         DISCHARGE_ENABLE_BIT_BIT      = 0;
  localparam int         FORCED_PULSE_MODE_BIT_BIT       = 2;
  localparam int         SW_EN_BIT      = 0;
  localparam int         CHIP_DIS_BIT   = 7;
  // reset values; forced_pulse_mode_bit bit is replaced by the trim at release
  localparam logic [7:0] RST_SETPOINT   = 8'h32;
  localparam logic [7:0] RST_CONTROL_0  = 8'h01;
  localparam logic [7:0] RST_CONTROL_1  = 8'h01;
  // valid setpoint code window
  localparam logic [5:0] CODE_MIN       = 6'h14;
  localparam logic [5:0] CODE_MAX       = 6'h37;
  // reference scale of the analog converter
  localparam int         REF_BASE_MV    = 400;
  localparam int         REF_STEP_MV    = 20;
  // voltage scaling step time
  localparam int         CLK_PERIOD_PS  = 4000;
  localparam int         DVS_STEP_NS    = 12000;
  localparam int         DVS_CYCLES     = (DVS_STEP_NS * 1000) / CLK_PERIOD_PS;
  localparam int         DVS_CNT_W      = 12;
  // serial bit count per byte
  localparam logic [3:0] BYTE_BITS      = 4'h8;

  typedef struct packed {
    logic       conv_enable;
    logic       forced_pwm;
    logic       discharge_on;
    logic [5:0] ref_code;
    logic       ref_at_target;
  } bcrd_conv_ctl_type;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR,
    ST_WDATA, ST_ACK_DATA, ST_TX, ST_TX_ACK
  } bcrd_state_type;
endpackage

// File: src/bcrd_regs.sv
// buck regulator control registers, serial slave and reference ramp
`timescale 1ns/1ps
`default_nettype none
module bcrd_regs
  import bcrd_pkg::*;
#(
  parameter int DVS_STEP_CYCLES = DVS_CYCLES
) (
  // clock and power-on reset
  input  wire logic              core_clk,
  input  wire logic              rstn,
  // pins
  input  wire logic              en_pin,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  // factory trim
  input  wire logic              trim_forced_pwm,
  // analog side
  output bcrd_conv_ctl_type      conv_ctl
);

  // pin history for edge detection
  logic scl_prev_reg, sda_prev_reg;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_in;
      sda_prev_reg <= sda_in;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_in && !scl_prev_reg;
  assign scl_fall  = !scl_in && scl_prev_reg;
  assign bus_start = scl_in && scl_prev_reg && sda_prev_reg && !sda_in;
  assign bus_stop  = scl_in && scl_prev_reg && !sda_prev_reg && sda_in;

  // register file
  logic [7:0] setpoint_reg, setpoint_next;
  logic [7:0] control_zero_reg, control_zero_next;
  logic [7:0] control_one_reg, control_one_next;
  logic       trim_done_reg, trim_done_next;
  logic       wr_en;
  logic [7:0] wr_addr, wr_data;

  // serial slave state
  bcrd_state_type state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic [7:0] tx_sh_reg, tx_sh_next;
  logic [7:0] ptr_reg, ptr_next;
  logic       oe_reg, oe_next;
  logic       rw_reg, rw_next;
  logic       mack_reg, mack_next;

  function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] s,
                                          input logic [7:0] c0, input logic [7:0] c1);
    case (a)
      OFS_SETPOINT:  read_reg = s;
      OFS_CONTROL_0: read_reg = c0;
      OFS_CONTROL_1: read_reg = c1;
      default:       read_reg = 8'h00;
    endcase
  endfunction

  always_comb begin
    state_next   = state_reg;
    bit_cnt_next = bit_cnt_reg;
    rx_sh_next   = rx_sh_reg;
    tx_sh_next   = tx_sh_reg;
    ptr_next     = ptr_reg;
    oe_next      = oe_reg;
    rw_next      = rw_reg;
    mack_next    = mack_reg;
    wr_en        = 1'b0;
    wr_addr      = ptr_reg;
    wr_data      = rx_sh_reg;
    if (bus_stop) begin
      state_next = ST_IDLE;
      oe_next    = 1'b0;
    end else if (bus_start) begin
      state_next   = ST_ADDR;
      bit_cnt_next = 4'h0;
      oe_next      = 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          oe_next = 1'b0;
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            rx_sh_next   = {rx_sh_reg[6:0], sda_in};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == BYTE_BITS) begin
            oe_next = 1'b1;
            if (state_reg == ST_ADDR) begin
              // foreign address: stay off the bus until next start
              if (rx_sh_reg[7:1] == SLAVE_ADDR) begin
                rw_next    = rx_sh_reg[0];
                state_next = ST_ACK_ADDR;
              end else begin
                oe_next    = 1'b0;
                state_next = ST_IDLE;
              end
            end else if (state_reg == ST_PTR) begin
              ptr_next   = rx_sh_reg;
              state_next = ST_ACK_PTR;
            end else begin
              wr_en      = 1'b1;
              state_next = ST_ACK_DATA;
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_PTR, ST_ACK_DATA: begin
          if (scl_fall) begin
            bit_cnt_next = 4'h0;
            oe_next      = 1'b0;
            state_next   = ST_WDATA;
            if (state_reg == ST_ACK_ADDR && !rw_reg) begin
              state_next = ST_PTR;
            end else if (state_reg == ST_ACK_ADDR) begin
              tx_sh_next = read_reg(ptr_reg, setpoint_reg, control_zero_reg, control_one_reg);
              oe_next    = !tx_sh_next[7];
              state_next = ST_TX;
            end else if (state_reg == ST_ACK_DATA) begin
              ptr_next = ptr_reg + 8'h01;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == BYTE_BITS) begin
              oe_next    = 1'b0;
              state_next = ST_TX_ACK;
            end else begin
              tx_sh_next = {tx_sh_reg[6:0], 1'b0};
              oe_next    = !tx_sh_next[7];
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            mack_next = !sda_in;
          end else if (scl_fall) begin
            if (mack_reg) begin
              ptr_next     = ptr_reg + 8'h01;
              tx_sh_next   = read_reg(ptr_next, setpoint_reg, control_zero_reg,
                                      control_one_reg);
              oe_next      = !tx_sh_next[7];
              bit_cnt_next = 4'h0;
              state_next   = ST_TX;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        default: begin
          state_next = ST_IDLE;
          oe_next    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_sh_reg   <= 8'h00;
      tx_sh_reg   <= 8'h00;
      ptr_reg     <= 8'h00;
      oe_reg      <= 1'b0;
      rw_reg      <= 1'b0;
      mack_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_sh_reg   <= rx_sh_next;
      tx_sh_reg   <= tx_sh_next;
      ptr_reg     <= ptr_next;
      oe_reg      <= oe_next;
      rw_reg      <= rw_next;
      mack_reg    <= mack_next;
    end
  end

  // registers; trim caught one cycle after release since reset takes constants only
  always_comb begin
    setpoint_next     = setpoint_reg;
    control_zero_next = control_zero_reg;
    control_one_next  = control_one_reg;
    trim_done_next    = 1'b1;
    if (!trim_done_reg) begin
      control_zero_next[FORCED_PULSE_MODE_BIT_BIT] = trim_forced_pwm;
    end
    if (wr_en) begin
      case (wr_addr)
        OFS_SETPOINT:  setpoint_next     = wr_data;
        OFS_CONTROL_0: control_zero_next = wr_data;
        OFS_CONTROL_1: control_one_next  = wr_data;
        default:       setpoint_next     = setpoint_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      setpoint_reg     <= RST_SETPOINT;
      control_zero_reg <= RST_CONTROL_0;
      control_one_reg  <= RST_CONTROL_1;
      trim_done_reg    <= 1'b0;
    end else begin
      setpoint_reg     <= setpoint_next;
      control_zero_reg <= control_zero_next;
      control_one_reg  <= control_one_next;
      trim_done_reg    <= trim_done_next;
    end
  end

  // reference ramp; out-of-window codes are clamped to the valid range
  logic [5:0]           target_code;
  logic [5:0]           ref_reg, ref_next;
  logic [DVS_CNT_W-1:0] dvs_cnt_reg, dvs_cnt_next;
  logic                 conv_en;
  bcrd_conv_ctl_type    ctl_next;

  always_comb begin
    target_code = setpoint_reg[SETPOINT_W-1:0];
    if (target_code < CODE_MIN) target_code = CODE_MIN;
    if (target_code > CODE_MAX) target_code = CODE_MAX;
    ref_next     = ref_reg;
    dvs_cnt_next = '0;
    if (ref_reg != target_code) begin
      dvs_cnt_next = dvs_cnt_reg + 1'b1;
      if (dvs_cnt_reg == DVS_CNT_W'(DVS_STEP_CYCLES - 1)) begin
        dvs_cnt_next = '0;
        ref_next     = (ref_reg < target_code) ? ref_reg + 6'h01 : ref_reg - 6'h01;
      end
    end
    conv_en = en_pin && control_one_reg[SW_EN_BIT]
              && !control_one_reg[CHIP_DIS_BIT];
    ctl_next.conv_enable   = conv_en;
    ctl_next.forced_pwm    = control_zero_reg[FORCED_PULSE_MODE_BIT_BIT];
    ctl_next.discharge_on  = !conv_en && control_zero_reg[DISCHARGE_ENABLE_BIT_BIT];
    ctl_next.ref_code      = ref_reg;
    ctl_next.ref_at_target = (ref_reg == target_code);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ref_reg     <= RST_SETPOINT[SETPOINT_W-1:0];
      dvs_cnt_reg <= '0;
      conv_ctl    <= '0;
      sda_out     <= 1'b0;
      sda_oe      <= 1'b0;
    end else begin
      ref_reg     <= ref_next;
      dvs_cnt_reg <= dvs_cnt_next;
      conv_ctl    <= ctl_next;
      sda_out     <= 1'b0;
      sda_oe      <= oe_next;
    end
  end

  // checks
  property p_shutdown;
    @(posedge core_clk) disable iff (!rstn) !en_pin |=> !conv_ctl.conv_enable;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("converter on with pin low");

  property p_sw_enable;
    @(posedge core_clk) disable iff (!rstn)
      en_pin && !control_one_reg[SW_EN_BIT] |=> !conv_ctl.conv_enable;
  endproperty
  a_sw_enable: assert property (p_sw_enable) else $error("software disable ignored");

  property p_discharge;
    @(posedge core_clk) disable iff (!rstn)
      conv_ctl.discharge_on |-> !conv_ctl.conv_enable;
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge while running");

  property p_ref_window;
    @(posedge core_clk) disable iff (!rstn)
      trim_done_reg |-> ref_reg >= CODE_MIN && ref_reg <= CODE_MAX;
  endproperty
  a_ref_window: assert property (p_ref_window) else $error("reference out of window");

  property p_single_step;
    @(posedge core_clk) disable iff (!rstn)
      ref_reg != $past(ref_reg) |-> ref_reg == $past(ref_reg) + 6'h01
                                    || ref_reg == $past(ref_reg) - 6'h01;
  endproperty
  a_single_step: assert property (p_single_step) else $error("reference jumped");

  property p_step_spacing;
    @(posedge core_clk) disable iff (!rstn)
      ref_next != ref_reg |-> dvs_cnt_reg == DVS_CNT_W'(DVS_STEP_CYCLES - 1);
  endproperty
  a_step_spacing: assert property (p_step_spacing) else $error("step too early");

  property p_ramp_starts;
    @(posedge core_clk) disable iff (!rstn)
      ref_reg != target_code |=> dvs_cnt_reg != '0 || ref_reg != $past(ref_reg);
  endproperty
  a_ramp_starts: assert property (p_ramp_starts) else $error("ramp did not run");

  property p_foreign_addr;
    @(posedge core_clk) disable iff (!rstn)
      state_reg == ST_ADDR && scl_fall && bit_cnt_reg == BYTE_BITS
      && rx_sh_reg[7:1] != SLAVE_ADDR && !bus_start && !bus_stop |=> !sda_oe;
  endproperty
  a_foreign_addr: assert property (p_foreign_addr) else $error("acked foreign address");

  property p_ptr_advance;
    @(posedge core_clk) disable iff (!rstn)
      state_reg == ST_ACK_DATA && scl_fall && !bus_start && !bus_stop
      |=> ptr_reg == $past(ptr_reg) + 8'h01;
  endproperty
  a_ptr_advance: assert property (p_ptr_advance) else $error("pointer not advanced");

  c_write:   cover property (@(posedge core_clk) disable iff (!rstn) wr_en);
  c_read:    cover property (@(posedge core_clk) disable iff (!rstn)
                             state_reg == ST_TX_ACK && mack_reg);
  c_ramp:    cover property (@(posedge core_clk) disable iff (!rstn)
                             !conv_ctl.ref_at_target ##1 conv_ctl.ref_at_target);
  c_dis:     cover property (@(posedge core_clk) disable iff (!rstn) conv_ctl.discharge_on);

endmodule
`default_nettype wire

// File: verification/bcrd_i2c_master.sv
// two-wire bus master model reaching the register block from outside
`timescale 1ns/1ps
`default_nettype none
module bcrd_i2c_master
  import bcrd_pkg::*;
(
  // pacing clock
  input  wire logic core_clk,
  // bus lines, released high
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda_wire
);
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end
  // four cycles a phase, twice the slave's floor
  task automatic half();
    repeat (4) @(negedge core_clk);
  endtask
  task automatic start();
    sda_m = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_m = 1'b0;
    half();
    scl = 1'b0;
    half();
  endtask
  task automatic stop();
    sda_m = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_m = 1'b1;
    half();
  endtask
  // sample at the end of the high phase; data moves only a phase after scl falls
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    half();
    scl = 1'b1;
    half();
    r = sda_wire;
    scl = 1'b0;
    half();
  endtask
  task automatic xbyte(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                       output logic nak);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(last, nak);
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [15:0] d,
                    input int n, output logic nak);
    logic [7:0] rx;
    logic       a;
    start();
    xbyte({dev, 1'b0}, 1'b1, rx, nak);
    if (nak !== 1'b1) begin
      // only mapped offsets are ever written here
      xbyte(ptr, 1'b1, rx, a);
      for (int i = n - 1; i >= 0; i--) xbyte(d[8*i +: 8], 1'b1, rx, a);
    end
    stop();
  endtask
  task automatic rd(input logic [7:0] ptr, input int n, output logic [15:0] q);
    logic [7:0] rx;
    logic       a;
    q = 16'h0000;
    start();
    xbyte({SLAVE_ADDR, 1'b0}, 1'b1, rx, a);
    xbyte(ptr, 1'b1, rx, a);
    start();
    xbyte({SLAVE_ADDR, 1'b1}, 1'b1, rx, a);
    // last byte refused so the slave lets go of the line
    for (int i = n - 1; i >= 0; i--) begin
      xbyte(8'hFF, i == 0, rx, a);
      q[8*i +: 8] = rx;
    end
    stop();
  endtask
endmodule
`default_nettype wire

// File: verification/bcrd_regs_tb_top.sv
// self-checking bench for the buck control register block
`timescale 1ns/1ps
`default_nettype none
module bcrd_regs_tb_top;
  import bcrd_pkg::*;
  localparam int STEP = 5;
  logic              core_clk;
  logic              rstn;
  logic              en_pin;
  logic              trim_forced_pwm;
  logic              sda_out;
  logic              sda_oe;
  logic              scl;
  logic              sda_m;
  logic              nak;
  wire               sda_wire;
  bcrd_conv_ctl_type conv_ctl;
  logic [15:0]       q;
  logic [5:0]        prev_code;
  logic              stepped;
  logic              seen_target;
  int                n_mismatch;
  int                n_checks;
  int                cyc = 0;
  int                gap;
  int                live;
  logic [7:0]        c1_val [3] = '{8'h00, 8'h81, 8'h01};
  logic              c1_on  [3] = '{1'b0, 1'b0, 1'b1};

  // pull-up on the data line; each side can only pull low
  assign sda_wire = sda_m & (~sda_oe | sda_out);

  bcrd_regs #(.DVS_STEP_CYCLES(STEP)) bcrd_regs_inst (.core_clk(core_clk), .rstn(rstn),
    .en_pin(en_pin), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .trim_forced_pwm(trim_forced_pwm), .conv_ctl(conv_ctl));
  bcrd_i2c_master bcrd_i2c_master_inst (.core_clk(core_clk), .scl(scl), .sda_m(sda_m),
    .sda_wire(sda_wire));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ramp watcher: every code change is one step, spaced by the step count
  always @(posedge core_clk) begin
    if (rstn !== 1'b1) begin
      live    = 0;
      stepped = 1'b0;
    end else begin
      if (live > 3 && conv_ctl.ref_code !== prev_code) begin
        chk({15'h0, conv_ctl.ref_code == prev_code + 6'h01 ||
             conv_ctl.ref_code == prev_code - 6'h01}, 16'h0001, "ramp step");
        if (stepped && !seen_target) chk(16'(gap), 16'(STEP - 1), "step spacing");
        stepped     = 1'b1;
        seen_target = 1'b0;
        gap         = 0;
      end else begin
        gap++;
        if (conv_ctl.ref_at_target === 1'b1) seen_target = 1'b1;
      end
      live++;
    end
    prev_code = conv_ctl.ref_code;
  end

  task automatic wait_ref(input logic [5:0] exp, input int steps);
    for (int i = 0; i < (steps + 2) * (STEP + 2); i++) begin
      if (conv_ctl.ref_code === exp && conv_ctl.ref_at_target === 1'b1) break;
      @(negedge core_clk);
    end
    chk({9'h0, conv_ctl.ref_code, conv_ctl.ref_at_target}, {9'h0, exp, 1'b1}, "ramp end");
  endtask

  initial begin
    rstn            = 1'b0;
    en_pin          = 1'b0;
    trim_forced_pwm = 1'b1;
    n_mismatch      = 0;
    n_checks        = 0;
    repeat (2) @(negedge core_clk);
    chk({6'h0, conv_ctl}, 16'h0000, "ctl in reset");
    rstn = 1'b1;
    repeat (3) @(negedge core_clk);
    chk({6'h0, conv_ctl}, {6'h0, 3'b011, RST_SETPOINT[5:0], 1'b1}, "off");
    bcrd_i2c_master_inst.rd(OFS_SETPOINT, 2, q);
    chk(q, {RST_SETPOINT, RST_CONTROL_0 | (8'h01 << FORCED_PULSE_MODE_BIT_BIT)}, "dflt");
    bcrd_i2c_master_inst.rd(OFS_CONTROL_1, 1, q);
    chk(q, {8'h00, RST_CONTROL_1}, "control_one dflt");
    bcrd_i2c_master_inst.rd(8'h02, 1, q);
    chk(q, 16'h0000, "unmapped");
    en_pin = 1'b1;
    repeat (3) @(negedge core_clk);
    chk({6'h0, conv_ctl}, {6'h0, 3'b110, RST_SETPOINT[5:0], 1'b1}, "on");
    foreach (c1_val[i]) begin
      bcrd_i2c_master_inst.wr(SLAVE_ADDR, OFS_CONTROL_1, {8'h00, c1_val[i]}, 1, nak);
      chk({15'h0, nak}, 16'h0000, "ack");
      chk({14'h0, conv_ctl.conv_enable, conv_ctl.discharge_on},
          {14'h0, c1_on[i], ~c1_on[i]}, "sw en");
    end
    bcrd_i2c_master_inst.wr(SLAVE_ADDR, OFS_SETPOINT, 16'h3500, 2, nak);
    wait_ref(6'h35, 3);
    bcrd_i2c_master_inst.rd(OFS_SETPOINT, 2, q);
    chk(q, 16'h3500, "burst");
    en_pin = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({13'h0, conv_ctl[9:7]}, 16'h0000, "no discharge");
    bcrd_i2c_master_inst.wr(SLAVE_ADDR, OFS_CONTROL_0, 16'h0005, 1, nak);
    chk({13'h0, conv_ctl[9:7]}, 16'h0003, "pwm discharge");
    bcrd_i2c_master_inst.wr(SLAVE_ADDR, OFS_SETPOINT, 16'h0000, 1, nak);
    wait_ref(CODE_MIN, 33);
    bcrd_i2c_master_inst.wr(SLAVE_ADDR, OFS_SETPOINT, 16'h003F, 1, nak);
    wait_ref(CODE_MAX, 35);
    bcrd_i2c_master_inst.wr(SLAVE_ADDR, OFS_SETPOINT, {10'h0, CODE_MAX}, 1, nak);
    chk({15'h0, conv_ctl.ref_at_target}, 16'h0001, "same code");
    bcrd_i2c_master_inst.wr(SLAVE_ADDR ^ 7'h01, OFS_SETPOINT, 16'h0020, 1, nak);
    chk({15'h0, nak}, 16'h0001, "foreign addr");
    bcrd_i2c_master_inst.rd(OFS_SETPOINT, 1, q);
    chk(q, {10'h0, CODE_MAX}, "kept");
    rstn            = 1'b0;
    trim_forced_pwm = 1'b0;
    repeat (2) @(negedge core_clk);
    rstn   = 1'b1;
    en_pin = 1'b1;
    repeat (3) @(negedge core_clk);
    chk({6'h0, conv_ctl}, {6'h0, 3'b100, RST_SETPOINT[5:0], 1'b1}, "rerun");
    bcrd_i2c_master_inst.rd(OFS_SETPOINT, 2, q);
    chk(q, {RST_SETPOINT, RST_CONTROL_0}, "dflt again");
    final_report();
  end
endmodule
`default_nettype wire
